// ==== hdl/cache_flush_timer.sv ====
// Cache flush busy timer for write-back configurations
`timescale 1ns/10ps
`default_nettype none
`include "mgmt_consts.svh"
module cache_flush_timer #(
  parameter int FLUSH_CLOCKS = `FLUSH_WB_CLOCKS
) (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  input  wire logic flush_req_in,
  input  wire logic writeback_in,
  output logic      busy_out
);
  localparam int CW = $clog2(FLUSH_CLOCKS + 1);
  localparam logic [CW-1:0] LOAD = CW'(FLUSH_CLOCKS);

  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  wire           start = flush_req_in & writeback_in & (cnt_q == '0);

  // Write-through flushes cost nothing, so only write-back loads the count
  always_comb begin
    cnt_d = cnt_q;
    if (start) begin
      cnt_d = LOAD;
    end else if (cnt_q != '0) begin
      cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  assign busy_out = (cnt_q != '0);

  a_flush_length: assert property (@(posedge clk_in) disable iff (!resetn_in)
    start |=> (cnt_q == LOAD) ##1 busy_out[*8])
    else $error("write-back flush shorter than required");

  a_wt_no_delay: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (!writeback_in && !busy_out) |=> !busy_out)
    else $error("write-through flush took a delay");
endmodule
`default_nettype wire

// ==== hdl/io_trap_capture.sv ====
// I/O trap word capture at mode entry
`timescale 1ns/10ps
`default_nettype none
`include "mgmt_consts.svh"
module io_trap_capture (
  input  wire logic clk_in,
  input  wire logic resetn_in,
  trap_if.cap       tp
);
  logic [31:0] word_q;
  logic [31:0] word_d;

  assign tp.word = word_q;

  // ==========================================================================
  // Capture
  always_comb begin
    word_d = word_q;
    if (tp.capture) begin
      word_d = 32'h0000_0000;
      word_d[`TRAP_ADDR_MSB:`TRAP_ADDR_LSB] = tp.io_addr;
      word_d[`TRAP_VALID_BIT] = tp.io_valid & ~tp.suppress;
      word_d[`TRAP_DIR_BIT]   = tp.io_read;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      word_q <= 32'h0000_0000;
    end else begin
      word_q <= word_d;
    end
  end

  a_trap_reserved: assert property (@(posedge clk_in) disable iff (!resetn_in)
    word_q[`TRAP_RSVD_MSB:`TRAP_RSVD_LSB] == 14'h0000)
    else $error("trap word reserved bits not zero");

  a_trap_fields: assert property (@(posedge clk_in) disable iff (!resetn_in)
    tp.capture |=> (word_q[`TRAP_DIR_BIT] == $past(tp.io_read)) &&
                   (word_q[`TRAP_ADDR_MSB:`TRAP_ADDR_LSB] == $past(tp.io_addr)))
    else $error("trap address or direction not captured");
endmodule
`default_nettype wire

// ==== hdl/mgmt_mode_ctrl.sv ====
// Management mode controller: trap restart, RAM base relocation, register slave
`timescale 1ns/10ps
`default_nettype none
`include "mgmt_consts.svh"
module mgmt_mode_ctrl #(
  parameter int FLUSH_CLOCKS = `FLUSH_WB_CLOCKS
) (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [15:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output logic [31:0]      wb_dat_out,
  output logic             wb_ack_out,
  input  wire logic        mgmt_interrupt_request_n_in,
  input  wire logic        resume_instruction_in,
  input  wire logic [15:0] io_access_addr_in,
  input  wire logic        io_access_read_in,
  input  wire logic        io_instr_valid_in,
  input  wire logic        flush_n_in,
  input  wire logic        writeback_invalidate_instruction_in,
  input  wire logic        writeback_select_in,
  output logic             mgmt_mode_active_n_out,
  output logic [31:0]      entry_vector_out,
  output logic [31:0]      save_top_out,
  output logic             restart_io_out,
  output logic             resume_done_out,
  output logic             shutdown_out,
  output logic             flush_busy_out
);

  // ==========================================================================
  // State
  mgmt_pkg::mode_state_t state_q;
  mgmt_pkg::mode_state_t state_d;

  logic [31:0] base_q;
  logic [31:0] base_d;
  logic [31:0] base_slot_q;
  logic [31:0] base_slot_d;
  logic [15:0] restart_slot_q;
  logic [15:0] restart_slot_d;
  logic        pending_q;
  logic        pending_d;
  logic        back_to_back_q;
  logic        back_to_back_d;
  logic        req_prev_q;
  logic        restart_q;
  logic        restart_d;
  logic        done_q;
  logic        done_d;
  logic [31:0] vector_q;
  logic [31:0] save_top_q;
  logic        ack_q;
  logic [31:0] dat_q;
  logic        resumed_q;

  trap_if tp ();

  // ==========================================================================
  // Request and resume decode
  wire req_level   = ~mgmt_interrupt_request_n_in;
  wire req_edge    = req_level & ~req_prev_q;
  wire in_active   = (state_q == mgmt_pkg::ST_ACTIVE);
  wire in_entry    = (state_q == mgmt_pkg::ST_ENTRY);
  wire in_idle     = (state_q == mgmt_pkg::ST_IDLE);
  wire resume_go   = in_active & resume_instruction_in;
  wire slot_aligned = ((base_slot_q & `ALIGN_MASK) == 32'h0000_0000);
  wire restart_set = (restart_slot_q == `RESTART_YES);
  // A request seen while busy in the mode is held for the next entry
  wire req_while_busy = req_edge & ~in_idle;

  // ==========================================================================
  // Register bus decode
  wire bus_req     = wb_cyc_in & wb_stb_in & ~ack_q;
  wire bus_wr      = bus_req & wb_we_in;
  wire hit_base    = (wb_adr_in == `MGMT_BASE_SLOT_OFF);
  wire hit_restart = (wb_adr_in == `IO_RESTART_SLOT_OFF);
  wire hit_trap    = (wb_adr_in == `IO_TRAP_WORD_OFF);
  wire hit_rev     = (wb_adr_in == `REVISION_ID_OFF);
  wire hit_status  = (wb_adr_in == `MODE_STATUS_OFF);
  wire [31:0] status_word = {27'h0000000, flush_busy_out, pending_q, back_to_back_q,
                             (state_q == mgmt_pkg::ST_SHUTDOWN), ~mgmt_mode_active_n_out};
  wire [31:0] restart_merged = mgmt_pkg::lane_merge({16'h0000, restart_slot_q},
                                                     wb_dat_in, wb_sel_in);
  // Unmapped addresses answer normally with zero data; writes there vanish
  wire [31:0] rd_data = hit_base    ? base_slot_q :
                        hit_restart ? {16'h0000, restart_slot_q} :
                        hit_trap    ? tp.word :
                        hit_rev     ? `REVISION_ID :
                        hit_status  ? status_word :
                                      32'h0000_0000;

  // ==========================================================================
  // Trap capture link
  assign tp.io_addr  = io_access_addr_in;
  assign tp.io_read  = io_access_read_in;
  assign tp.io_valid = io_instr_valid_in;
  assign tp.capture  = in_entry;
  assign tp.suppress = back_to_back_q;

  io_trap_capture u_trap (
    .clk_in    (clk_in),
    .resetn_in (resetn_in),
    .tp        (tp)
  );

  // Flushes start only from the pin or the invalidate instruction
  cache_flush_timer #(
    .FLUSH_CLOCKS (FLUSH_CLOCKS)
  ) u_flush (
    .clk_in       (clk_in),
    .resetn_in    (resetn_in),
    .flush_req_in (~flush_n_in | writeback_invalidate_instruction_in),
    .writeback_in (writeback_select_in),
    .busy_out     (flush_busy_out)
  );

  // ==========================================================================
  // Mode sequencing
  always_comb begin
    state_d        = state_q;
    base_d         = base_q;
    pending_d      = pending_q | req_while_busy;
    back_to_back_d = back_to_back_q;
    restart_d      = 1'b0;
    done_d         = 1'b0;
    unique case (state_q)
      mgmt_pkg::ST_IDLE: begin
        if (req_level) begin
          state_d        = mgmt_pkg::ST_ENTRY;
          back_to_back_d = 1'b0;
        end
      end
      mgmt_pkg::ST_ENTRY: begin
        state_d = mgmt_pkg::ST_ACTIVE;
      end
      mgmt_pkg::ST_ACTIVE: begin
        if (resume_go) begin
          if (!slot_aligned) begin
            state_d = mgmt_pkg::ST_SHUTDOWN;
          end else begin
            base_d    = base_slot_q;
            restart_d = restart_set;
            done_d    = 1'b1;
            if (pending_q | req_edge) begin
              state_d        = mgmt_pkg::ST_ENTRY;
              back_to_back_d = 1'b1;
              pending_d      = 1'b0;
            end else begin
              state_d = mgmt_pkg::ST_IDLE;
            end
          end
        end
      end
      mgmt_pkg::ST_SHUTDOWN: begin
        state_d   = mgmt_pkg::ST_SHUTDOWN;
        pending_d = 1'b0;
      end
      default: begin
        state_d = mgmt_pkg::ST_SHUTDOWN;
      end
    endcase
  end

  // ==========================================================================
  // Slot updates: hardware entry writes take priority over software
  always_comb begin
    base_slot_d    = base_slot_q;
    restart_slot_d = restart_slot_q;
    if (bus_wr && hit_base) begin
      base_slot_d = mgmt_pkg::lane_merge(base_slot_q, wb_dat_in, wb_sel_in);
    end
    if (bus_wr && hit_restart) begin
      restart_slot_d = restart_merged[15:0];
    end
    if (in_entry) begin
      base_slot_d    = base_q;
      restart_slot_d = `RESTART_NO;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q        <= mgmt_pkg::ST_IDLE;
      base_q         <= `BASE_RESET;
      base_slot_q    <= `BASE_RESET;
      restart_slot_q <= `RESTART_NO;
      pending_q      <= 1'b0;
      back_to_back_q <= 1'b0;
      req_prev_q     <= 1'b0;
      restart_q      <= 1'b0;
      done_q         <= 1'b0;
    end else begin
      state_q        <= state_d;
      base_q         <= base_d;
      base_slot_q    <= base_slot_d;
      restart_slot_q <= restart_slot_d;
      pending_q      <= pending_d;
      back_to_back_q <= back_to_back_d;
      req_prev_q     <= req_level;
      restart_q      <= restart_d;
      done_q         <= done_d;
    end
  end

  // ==========================================================================
  // Derived addresses, registered from the next base
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      vector_q   <= `BASE_RESET + `VECTOR_OFS;
      save_top_q <= `BASE_RESET + `VECTOR_OFS + `SAVE_TOP_OFS;
    end else begin
      vector_q   <= mgmt_pkg::add_ofs(base_d, `VECTOR_OFS);
      save_top_q <= mgmt_pkg::add_ofs(base_d, `VECTOR_OFS + `SAVE_TOP_OFS);
    end
  end

  // ==========================================================================
  // Wishbone slave: one wait-free answer cycle per request
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= bus_req;
      if (bus_req) begin
        dat_q <= rd_data;
      end
    end
  end

  // ==========================================================================
  // Outputs
  assign wb_ack_out             = ack_q;
  assign wb_dat_out             = dat_q;
  assign mgmt_mode_active_n_out = ~(in_entry | in_active);
  assign entry_vector_out       = vector_q;
  assign save_top_out           = save_top_q;
  assign restart_io_out         = restart_q;
  assign resume_done_out        = done_q;
  assign shutdown_out           = (state_q == mgmt_pkg::ST_SHUTDOWN);

  // ==========================================================================
  // Checks
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      resumed_q <= 1'b0;
    end else if (resume_go) begin
      resumed_q <= 1'b1;
    end
  end

  a_restart_taken: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (resume_go && slot_aligned && restart_slot_q == 16'h00ff) |=> restart_io_out ##1 !restart_io_out)
    else $error("restart slot 0ffh did not re-execute");

  a_restart_skip: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (resume_go && slot_aligned && restart_slot_q == 16'h0000) |=> !restart_io_out && resume_done_out)
    else $error("restart slot 00h re-executed");

  a_slot_cleared: assert property (@(posedge clk_in) disable iff (!resetn_in)
    in_entry |=> in_active && (restart_slot_q == 16'h0000))
    else $error("restart slot not cleared at entry");

  a_b2b_valid: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (resume_go && slot_aligned && pending_q) |=> in_entry ##1 !tp.word[1])
    else $error("second back-to-back entry marked trap word");

  a_valid_flag: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (in_entry && !back_to_back_q) |=> tp.word[1] == $past(io_instr_valid_in))
    else $error("valid flag not saved from instruction");

  a_base_reset: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !resumed_q |-> (base_q == 32'h0003_0000) && (entry_vector_out == 32'h0003_8000))
    else $error("base not at reset value");

  a_base_adopt: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (resume_go && slot_aligned) |=> base_q == $past(base_slot_q) ##1
      entry_vector_out == base_q + 32'h0000_8000)
    else $error("base slot not adopted on resume");

  a_misalign_stop: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (resume_go && base_slot_q[14:0] != 15'h0000) |=> shutdown_out[*3])
    else $error("misaligned base did not shut down");

  a_slot_gets_base: assert property (@(posedge clk_in) disable iff (!resetn_in)
    in_entry |=> (base_slot_q == $past(base_q)) && !mgmt_mode_active_n_out)
    else $error("entry did not store current base");

  a_save_top: assert property (@(posedge clk_in) disable iff (!resetn_in)
    $stable(base_q) |=> save_top_out == base_q + 32'h0000_ffff)
    else $error("save area top wrong");

  a_rev_reloc: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (bus_req && !wb_we_in && hit_rev) |=> wb_ack_out && wb_dat_out[17])
    else $error("relocation support not reported");

  a_no_self_flush: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (in_entry && flush_n_in && !writeback_invalidate_instruction_in && !flush_busy_out)
      |=> !flush_busy_out)
    else $error("flush started without a request");

  // Software slot writes land unless an entry overrides them in the same cycle
  a_slot_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (bus_wr && hit_restart && !in_entry && wb_sel_in == 4'hf) |=>
      restart_slot_q == $past(wb_dat_in[15:0]))
    else $error("restart slot write lost");

  a_base_write: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (bus_wr && hit_base && !in_entry && wb_sel_in == 4'hf) |=> base_slot_q == $past(wb_dat_in))
    else $error("base slot write lost");

  a_trap_read: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (bus_req && !wb_we_in && hit_trap) |=> wb_dat_out == $past(tp.word))
    else $error("trap word read back wrong");

  a_base_hold: assert property (@(posedge clk_in) disable iff (!resetn_in)
    !(resume_go && slot_aligned) |=> $stable(base_q))
    else $error("base changed outside resume");

  a_restart_other: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (resume_go && restart_slot_q != 16'h00ff) |=> !restart_io_out)
    else $error("restart without slot 0ffh");

  a_shut_sticky: assert property (@(posedge clk_in) disable iff (!resetn_in)
    shutdown_out |=> shutdown_out && !resume_done_out)
    else $error("shutdown state was left");

  a_b2b_marked: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (resume_go && slot_aligned && (pending_q || req_edge)) |=> in_entry && back_to_back_q)
    else $error("back-to-back request not marked");

  a_entry_starts: assert property (@(posedge clk_in) disable iff (!resetn_in)
    (in_idle && req_level) |=> in_entry && !mgmt_mode_active_n_out)
    else $error("request did not start entry");

  a_vector_track: assert property (@(posedge clk_in) disable iff (!resetn_in)
    entry_vector_out == base_q + 32'h0000_8000)
    else $error("entry vector does not follow base");

endmodule
`default_nettype wire

// ==== shared/mgmt_consts.svh ====
// Constants for the management mode trap and RAM base logic
`ifndef MGMT_CONSTS_SVH
`define MGMT_CONSTS_SVH

// ==========================================================================
// Register byte offsets
`define MGMT_BASE_SLOT_OFF   16'h7ef8
`define IO_RESTART_SLOT_OFF  16'h7f00
`define IO_TRAP_WORD_OFF     16'h7f04
`define REVISION_ID_OFF      16'h7f08
`define MODE_STATUS_OFF      16'h7f0c

// ==========================================================================
// Values and fields
`define BASE_RESET           32'h0003_0000
`define RESTART_YES          16'h00ff
`define RESTART_NO           16'h0000
`define VECTOR_OFS           32'h0000_8000
`define SAVE_TOP_OFS         32'h0000_7fff
`define ALIGN_MASK           32'h0000_7fff
`define REVISION_ID          32'h0003_0000
`define TRAP_ADDR_MSB        31
`define TRAP_ADDR_LSB        16
`define TRAP_RSVD_MSB        15
`define TRAP_RSVD_LSB        2
`define TRAP_VALID_BIT       1
`define TRAP_DIR_BIT         0
`define REV_RELOC_BIT        17
`define FLUSH_WB_CLOCKS      4100

`endif

// ==== shared/mgmt_pkg.sv ====
// Types and helper functions shared by the management mode logic
package mgmt_pkg;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ENTRY,
    ST_ACTIVE,
    ST_SHUTDOWN
  } mode_state_t;

  // Byte-lane merge for Wishbone writes
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [31:0] add_ofs(input logic [31:0] base,
                                          input logic [31:0] ofs);
    return base + ofs;
  endfunction

endpackage

// ==== shared/trap_if.sv ====
// Interface between the mode controller and the I/O trap capture unit
`timescale 1ns/10ps
`default_nettype none
interface trap_if;
  logic [15:0] io_addr;
  logic        io_read;
  logic        io_valid;
  logic        capture;
  logic        suppress;
  logic [31:0] word;

  modport cap (input io_addr, input io_read, input io_valid, input capture,
               input suppress, output word);
  modport ctl (output io_addr, output io_read, output io_valid, output capture,
               output suppress, input word);
endinterface
`default_nettype wire

// ==== tb/chipset_model.sv ====
// Chipset side model: management requests, trapped access, flush requests
`timescale 1ns/10ps
`default_nettype none
module chipset_model (
  input  wire logic        clk_in,
  input  wire logic        resetn_in,
  input  wire logic        trig_in,
  input  wire logic [15:0] addr_in,
  input  wire logic        read_in,
  input  wire logic        valid_in,
  input  wire logic        flush_cmd_in,
  input  wire logic        writeback_select_in,
  input  wire logic        mgmt_mode_active_n_in,
  output logic             mgmt_interrupt_request_n_out,
  output logic [15:0]      io_access_addr_out,
  output logic             io_access_read_out,
  output logic             io_instr_valid_out,
  output logic             flush_n_out,
  output logic             writeback_select_out,
  output logic             ram_gate_out
);
  logic act_q;
  logic auto_q;
  logic ram_open_q;
  // ==========================================================
  // Request line, trapped access and automatic flushes
  always @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      mgmt_interrupt_request_n_out <= 1'b1;
      io_access_addr_out <= 16'h0;
      io_access_read_out <= 1'b0;
      io_instr_valid_out <= 1'b0;
      act_q <= 1'b1;
      auto_q <= 1'b0;
      ram_open_q <= 1'b1;
    end else begin
      act_q <= mgmt_mode_active_n_in;
      // Boot code loads the handler while the RAM is open; the first request closes it
      if (trig_in) ram_open_q <= 1'b0;
      if (trig_in) begin
        mgmt_interrupt_request_n_out <= 1'b0;
        io_access_addr_out <= addr_in;
        io_access_read_out <= read_in;
        io_instr_valid_out <= valid_in;
      end else if (!mgmt_mode_active_n_in) begin
        // Access is over once the mode is entered: stale address must not linger
        mgmt_interrupt_request_n_out <= 1'b1;
        io_access_addr_out <= ~io_access_addr_out;
      end
      // Write-through flushes on each mode edge, write-back with the request
      auto_q <= writeback_select_in ? trig_in : (act_q != mgmt_mode_active_n_in);
    end
  end
  assign flush_n_out = !(auto_q | flush_cmd_in);
  // Processor only: RAM reachable in the mode or while opened for boot
  assign ram_gate_out = !mgmt_mode_active_n_in | ram_open_q;
  assign writeback_select_out = writeback_select_in & mgmt_mode_active_n_in;
endmodule
`default_nettype wire

// ==== tb/mgmt_mode_trap_and_ram_control_test.sv ====
// Self-checking bench for the management mode controller
`timescale 1ns/10ps
`default_nettype none
module mgmt_mode_trap_and_ram_control_test;
  localparam int FC = 16;
  logic        clk_in = 1'b0;
  logic        resetn_in = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, resume = 1'b0, wbinv = 1'b0;
  logic        wbsel = 1'b0, trig = 1'b0, t_read = 1'b0, t_valid = 1'b0, fcmd = 1'b0;
  logic [15:0] adr = 16'h0, t_addr = 16'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, m_base;
  wire  [31:0] rdat, vec, top;
  wire  [15:0] io_addr;
  wire         ack, req_n, io_read, io_valid, flush_n, active_n, restart, done, shut, busy;
  wire         wsel_pin, ram_gate;
  int          error_cnt = 0;
  int          checks_done = 0;

  always #5 clk_in = ~clk_in;

  mgmt_mode_ctrl #(.FLUSH_CLOCKS(FC)) mgmt_mode_ctrl_inst (.clk_in(clk_in),
    .resetn_in(resetn_in), .wb_cyc_in(cyc), .wb_stb_in(stb), .wb_we_in(we),
    .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_ack_out(ack),
    .mgmt_interrupt_request_n_in(req_n), .resume_instruction_in(resume),
    .io_access_addr_in(io_addr), .io_access_read_in(io_read), .io_instr_valid_in(io_valid),
    .flush_n_in(flush_n), .writeback_invalidate_instruction_in(wbinv),
    .writeback_select_in(wsel_pin), .mgmt_mode_active_n_out(active_n), .entry_vector_out(vec),
    .save_top_out(top), .restart_io_out(restart), .resume_done_out(done),
    .shutdown_out(shut), .flush_busy_out(busy));

  chipset_model chipset_model_inst (.clk_in(clk_in), .resetn_in(resetn_in), .trig_in(trig),
    .addr_in(t_addr), .read_in(t_read), .valid_in(t_valid), .flush_cmd_in(fcmd),
    .writeback_select_in(wbsel), .mgmt_mode_active_n_in(active_n),
    .mgmt_interrupt_request_n_out(req_n), .io_access_addr_out(io_addr),
    .io_access_read_out(io_read), .io_instr_valid_out(io_valid), .flush_n_out(flush_n),
    .writeback_select_out(wsel_pin), .ram_gate_out(ram_gate));

  // ==========================================================
  // Shared tasks
  task automatic conclude();
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Waits for ack without limit; only the watchdog ends a hung cycle
  task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'hf;
    do @(posedge clk_in); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic rdc(input logic [15:0] a, input logic [31:0] m, input logic [31:0] e,
                     input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e & m, what);
  endtask

  task automatic pulse_trig(input logic [15:0] a, input logic dir, input logic vld);
    trig <= 1'b1;
    t_addr <= a;
    t_read <= dir;
    t_valid <= vld;
    @(posedge clk_in);
    trig <= 1'b0;
    do @(posedge clk_in); while (active_n !== 1'b0);
  endtask

  task automatic resume_go();
    resume <= 1'b1;
    @(posedge clk_in);
    resume <= 1'b0;
    @(posedge clk_in);
  endtask

  task automatic session(input logic dir, input logic vld, input logic [15:0] slot,
                         input logic [31:0] nb, input logic b2b);
    logic [15:0] a;
    logic [31:0] q;
    a = 16'($urandom);
    pulse_trig(a, dir, vld);
    chk(32'(ram_gate), 32'h1, "ram in mode");
    rdc(16'h7f04, vld ? '1 : 32'h0000_fffe, {a, 14'h0, vld, dir}, "trap");
    rdc(16'h7f00, '1, 32'h0, "restart clr");
    rdc(16'h7ef8, '1, m_base, "base save");
    if (b2b) begin
      pulse_trig(a, dir, 1'b1);
      rdc(16'h7f0c, 32'h0000_0008, 32'h0000_0008, "pending");
    end
    wb(1'b1, 16'h7f00, {16'h0, slot}, q);
    wb(1'b1, 16'h7ef8, nb, q);
    resume_go();
    if (nb[14:0] != 15'h0) begin
      chk(32'(shut), 32'h1, "shutdown");
      chk(32'(done), 32'h0, "no done");
      rdc(16'h7f0c, 32'h0000_0002, 32'h0000_0002, "shut status");
    end else begin
      chk(32'(restart), 32'(slot == 16'h00ff), "restart");
      chk(32'(done), 32'h1, "done");
      chk(32'(ram_gate), 32'(b2b), "ram gate");
      chk(32'(active_n), 32'(!b2b), "active");
      m_base = nb;
      chk(vec, m_base + 32'h8000, "vector");
      chk(top, m_base + 32'hffff, "save top");
    end
    if (b2b) begin
      do @(posedge clk_in); while (active_n !== 1'b0);
      rdc(16'h7f04, 32'h0000_0002, 32'h0, "b2b valid");
      resume_go();
      chk(32'(done), 32'h1, "b2b done");
      chk(32'(restart), 32'h0, "b2b restart");
    end
    repeat (2) @(posedge clk_in);
  endtask

  task automatic flush_run(input logic wbm, input logic inv, input int exp);
    int n;
    n = 0;
    wbsel <= wbm;
    if (inv) wbinv <= 1'b1;
    else fcmd <= 1'b1;
    @(posedge clk_in);
    wbinv <= 1'b0;
    fcmd <= 1'b0;
    repeat (FC + 4) begin
      @(posedge clk_in);
      if (busy === 1'b1) n++;
    end
    chk(32'(n), 32'(exp), "flush len");
    wbsel <= 1'b0;
    @(posedge clk_in);
  endtask

  // Write-through traffic, entry flushes included, never leaves the unit busy
  always @(posedge clk_in) begin
    if (resetn_in && wbsel === 1'b0 && busy !== 1'b0) begin
      error_cnt++;
      $display("BAD %0t busy in write-through", $time);
    end
  end

  // ==========================================================
  // Main sequence and watchdog
  initial begin
    void'($urandom(79621));
    m_base = 32'h0003_0000;
    repeat (4) @(posedge clk_in);
    resetn_in <= 1'b1;
    @(posedge clk_in);
    rdc(16'h7ef8, '1, 32'h0003_0000, "base rst");
    rdc(16'h7f08, 32'h0002_0000, 32'h0002_0000, "reloc bit");
    rdc(16'h1234, '1, 32'h0, "unmapped");
    chk(vec, 32'h0003_8000, "vector rst");
    chk(top, 32'h0003_ffff, "top rst");
    chk(32'(ram_gate), 32'h1, "ram boot open");
    session(1'b1, 1'b1, 16'h00ff, 32'h0004_8000, 1'b0);
    session(1'b0, 1'b0, 16'h0000, $urandom & 32'hffff_8000, 1'b0);
    session(1'b1, 1'b1, 16'h0000, m_base, 1'b1);
    flush_run(1'b1, 1'b0, FC);
    flush_run(1'b1, 1'b1, FC);
    flush_run(1'b0, 1'b0, 0);
    session(1'b0, 1'b1, 16'h0000, m_base | 32'h0000_1000, 1'b0);
    conclude();
  end

  initial begin
    #100000;
    error_cnt++;
    $display("BAD %0t watchdog", $time);
    conclude();
  end
endmodule
`default_nettype wire
